/* suo_asserts.sv */
// checker: op handshake timing and lane mask / flag effects at the datapath ports
// assumes a bind to suo_scalar_unary_mask_ops, one clock domain
`timescale 1ns/1ps

module suo_asserts
  import suo_pkg::*;
(
  input wire logic        clk_sys_in,
  input wire logic        nrst_in,
  input wire logic        op_valid_in,
  input wire logic        op_ready_out,
  input wire suo_opcode_t op_code_in,
  input wire logic        op_done_out,
  input wire logic        mask_ld_in,
  input wire logic        rel_ld_in,
  input wire logic [63:0] lane_enable_mask_out,
  input wire logic        cond_flag_out,
  input wire logic [31:0] relative_index_register_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!nrst_in);

  // ****************
  // op classes
  // ****************
  suo_opcode_t op_r;
  logic        wide_m;
  logic        narrow_m;
  logic        quiet_m;
  logic        undef_m;

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      op_r <= 7'h00;
    end else if (op_valid_in && op_ready_out) begin
      op_r <= op_code_in;
    end
  end

  always_comb begin
    wide_m   = op_r inside {7'h2B, [7'h37:7'h3A]};
    narrow_m = op_r inside {[7'h3C:7'h47]};
    quiet_m  = op_r inside {[7'h2E:7'h31], 7'h3B, 7'h49};
    undef_m  = !(op_r inside {[7'h2B:7'h31], 7'h34, [7'h37:7'h47], 7'h49});
  end

  // ****************
  // properties
  // ****************
  chk_take_done: assert property (
    op_valid_in && op_ready_out |=> !op_ready_out ##1 (op_done_out && op_ready_out))
    else $error("done not two cycles after take");
  chk_done_cause: assert property (op_done_out |-> $past(op_valid_in && op_ready_out, 2))
    else $error("done without a taken op");
  chk_wide_flag: assert property (
    op_done_out && wide_m |-> cond_flag_out == (lane_enable_mask_out != 64'h0))
    else $error("wide mask flag mismatch");
  chk_narrow_half: assert property (
    op_done_out && narrow_m |-> lane_enable_mask_out[63:32] == $past(lane_enable_mask_out[63:32])
      && cond_flag_out == (lane_enable_mask_out[31:0] != 32'h0))
    else $error("narrow mask op wrong high half or flag");
  chk_move_quiet: assert property (
    op_done_out && quiet_m |-> $stable(lane_enable_mask_out) && $stable(cond_flag_out))
    else $error("move or doubling changed mask or flag");
  chk_undef_quiet: assert property (
    op_done_out && undef_m |-> lane_enable_mask_out == $past(lane_enable_mask_out)
      && cond_flag_out == $past(cond_flag_out))
    else $error("undefined op changed mask or flag");
  chk_mask_cause: assert property (
    $changed(lane_enable_mask_out) |-> op_done_out || $past(mask_ld_in && op_ready_out))
    else $error("mask changed without load or op");
  chk_rel_hold: assert property (
    $changed(relative_index_register_out) |-> $past(rel_ld_in && op_ready_out))
    else $error("relative index changed without load");

endmodule : suo_asserts

bind suo_scalar_unary_mask_ops suo_asserts u_suo_asserts (
  .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .op_valid_in(op_valid_in),
  .op_ready_out(op_ready_out), .op_code_in(op_code_in), .op_done_out(op_done_out),
  .mask_ld_in(mask_ld_in), .rel_ld_in(rel_ld_in), .lane_enable_mask_out(lane_enable_mask_out),
  .cond_flag_out(cond_flag_out), .relative_index_register_out(relative_index_register_out)
);

/* suo_map.svh */
// constants of the scalar unary mask/move datapath: opcodes, fields, reset values
// assumes nothing; guarded, so every file that uses a macro may include it
`ifndef SUO_MAP_SVH
`define SUO_MAP_SVH

// ****************************************
// opcode encodings
// ****************************************
`define SUO_OP_W                  7
`define SUO_OP_XNOR_SAVE_WIDE     7'h2B
`define SUO_OP_QUAD_NARROW        7'h2C
`define SUO_OP_QUAD_WIDE          7'h2D
`define SUO_OP_RELS_NARROW        7'h2E
`define SUO_OP_RELS_WIDE          7'h2F
`define SUO_OP_RELD_NARROW        7'h30
`define SUO_OP_RELD_WIDE          7'h31
`define SUO_OP_ABS                7'h34
`define SUO_OP_ANDN1_SAVE_WIDE    7'h37
`define SUO_OP_ORN1_SAVE_WIDE     7'h38
`define SUO_OP_ANDN1_WB_WIDE      7'h39
`define SUO_OP_ANDN2_WB_WIDE      7'h3A
`define SUO_OP_BIT_DOUBLE         7'h3B
`define SUO_OP_AND_SAVE_NARROW    7'h3C
`define SUO_OP_OR_SAVE_NARROW     7'h3D
`define SUO_OP_XOR_SAVE_NARROW    7'h3E
`define SUO_OP_ANDN2_SAVE_NARROW  7'h3F
`define SUO_OP_ORN2_SAVE_NARROW   7'h40
`define SUO_OP_NAND_SAVE_NARROW   7'h41
`define SUO_OP_NOR_SAVE_NARROW    7'h42
`define SUO_OP_XNOR_SAVE_NARROW   7'h43
`define SUO_OP_ANDN1_SAVE_NARROW  7'h44
`define SUO_OP_ORN1_SAVE_NARROW   7'h45
`define SUO_OP_ANDN1_WB_NARROW    7'h46
`define SUO_OP_ANDN2_WB_NARROW    7'h47
`define SUO_OP_DUAL_REL           7'h49

// ****************************************
// fields and reset values
// ****************************************
`define SUO_DUAL_SRC_MSB          9
`define SUO_DUAL_SRC_LSB          0
`define SUO_DUAL_DST_MSB          25
`define SUO_DUAL_DST_LSB          16
`define SUO_IDX_W                 7
`define SUO_MASK_RST              64'h0000000000000000
`define SUO_FLAG_RST              1'h0
`define SUO_REL_RST               32'h00000000

`endif

/* suo_mask_logic.sv */
// bitwise combiner of a source operand with the old lane enable mask
// assumes purely combinational use; narrow forms take the low half of the result
`timescale 1ns/1ps

module suo_mask_logic
  import suo_pkg::*;
(
  input  wire suo_lop_t    lop_in,
  input  wire logic [63:0] src_in,
  input  wire logic [63:0] mask_in,
  output logic      [63:0] result_out
);

  always_comb begin
    unique case (lop_in)
      SUO_LOP_AND:   result_out = src_in & mask_in;
      SUO_LOP_OR:    result_out = src_in | mask_in;
      SUO_LOP_XOR:   result_out = src_in ^ mask_in;
      SUO_LOP_ANDN1: result_out = ~src_in & mask_in;
      SUO_LOP_ANDN2: result_out = src_in & ~mask_in;
      SUO_LOP_ORN1:  result_out = ~src_in | mask_in;
      SUO_LOP_ORN2:  result_out = src_in | ~mask_in;
      SUO_LOP_NAND:  result_out = ~(src_in & mask_in);
      SUO_LOP_NOR:   result_out = ~(src_in | mask_in);
      SUO_LOP_XNOR:  result_out = ~(src_in ^ mask_in);
      default:       result_out = mask_in;
    endcase
  end

endmodule : suo_mask_logic

/* suo_mem_if.sv */
// pair-wide read and write port between the datapath and its scalar register file
// assumes both ends share clk_sys_in
`timescale 1ns/1ps
`include "suo_map.svh"

interface suo_mem_if #(
  parameter int IDX_W = `SUO_IDX_W
);
  logic [IDX_W-1:0] rd_idx;
  logic [31:0]      rd_lo;
  logic [31:0]      rd_hi;
  logic             we_lo;
  logic             we_hi;
  logic [IDX_W-1:0] wr_idx;
  logic [31:0]      wr_lo;
  logic [31:0]      wr_hi;

  modport mem  (input rd_idx, we_lo, we_hi, wr_idx, wr_lo, wr_hi, output rd_lo, rd_hi);
  modport user (output rd_idx, we_lo, we_hi, wr_idx, wr_lo, wr_hi, input rd_lo, rd_hi);
endinterface : suo_mem_if

/* suo_pkg.sv */
// types of the scalar unary mask/move datapath
// assumes suo_map.svh is on the include path
`include "suo_map.svh"

package suo_pkg;

  typedef logic [`SUO_OP_W-1:0] suo_opcode_t;

  typedef enum logic [3:0] {
    SUO_LOP_AND, SUO_LOP_OR, SUO_LOP_XOR, SUO_LOP_ANDN1, SUO_LOP_ANDN2,
    SUO_LOP_ORN1, SUO_LOP_ORN2, SUO_LOP_NAND, SUO_LOP_NOR, SUO_LOP_XNOR
  } suo_lop_t;

  typedef enum logic {
    SUO_ST_IDLE,
    SUO_ST_EXEC
  } suo_state_t;

endpackage : suo_pkg

/* suo_regfile.sv */
// scalar register file: reads the word at rd_idx and the next one, registered
// assumes the high word of a pair sits at index+1, wrapping at the top
`timescale 1ns/1ps
`include "suo_map.svh"

module suo_regfile
  import suo_pkg::*;
#(
  parameter int IDX_W = `SUO_IDX_W
) (
  input  wire logic clk_sys_in,
  input  wire logic nrst_in,
  suo_mem_if.mem    mem_if
);

  typedef struct packed {
    logic [31:0] lo;
    logic [31:0] hi;
  } suo_rd_t;

  logic [31:0]      store_q [2**IDX_W];
  logic [IDX_W-1:0] rd_hi_idx;
  logic [IDX_W-1:0] wr_hi_idx;
  suo_rd_t          rd_r;
  suo_rd_t          rd_nxt;

  assign rd_hi_idx = mem_if.rd_idx + IDX_W'(1);
  assign wr_hi_idx = mem_if.wr_idx + IDX_W'(1);

  // ****************************************
  // storage
  // ****************************************
  always_ff @(posedge clk_sys_in) begin
    if (mem_if.we_lo) begin
      store_q[mem_if.wr_idx] <= mem_if.wr_lo;
    end
    if (mem_if.we_hi) begin
      store_q[wr_hi_idx] <= mem_if.wr_hi;
    end
  end

  // ****************************************
  // registered read
  // ****************************************
  always_comb begin
    rd_nxt.lo = store_q[mem_if.rd_idx];
    rd_nxt.hi = store_q[rd_hi_idx];
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

  assign mem_if.rd_lo = rd_r.lo;
  assign mem_if.rd_hi = rd_r.hi;

endmodule : suo_regfile

/* suo_scalar_unary_mask_ops.sv */
// scalar single-source datapath: lane mask save/write-back, quad reduce,
// bit doubling, relative register moves and integer absolute value
// assumes the sequencer holds op fields stable while op_valid_in is high
`timescale 1ns/1ps
`include "suo_map.svh"

module suo_scalar_unary_mask_ops
  import suo_pkg::*;
#(
  parameter int IDX_W = `SUO_IDX_W
) (
  input  wire logic              clk_sys_in,
  input  wire logic              nrst_in,
  input  wire logic              op_valid_in,
  output logic                   op_ready_out,
  input  wire suo_opcode_t       op_code_in,
  input  wire logic [IDX_W-1:0]  op_src_idx_in,
  input  wire logic [IDX_W-1:0]  op_dst_idx_in,
  output logic                   op_done_out,
  input  wire logic              host_wr_en_in,
  input  wire logic [IDX_W-1:0]  host_wr_idx_in,
  input  wire logic [31:0]       host_wr_data_in,
  input  wire logic [IDX_W-1:0]  host_rd_idx_in,
  output logic      [31:0]       host_rd_data_out,
  input  wire logic              mask_ld_in,
  input  wire logic [63:0]       mask_ld_data_in,
  input  wire logic              rel_ld_in,
  input  wire logic [31:0]       rel_ld_data_in,
  output logic      [63:0]       lane_enable_mask_out,
  output logic                   cond_flag_out,
  output logic      [31:0]       relative_index_register_out
);

  typedef struct packed {
    suo_state_t       st;
    suo_opcode_t      op;
    logic [IDX_W-1:0] widx;
    logic [63:0]      mask;
    logic             flag;
    logic [31:0]      rel;
    logic             done;
  } suo_state_regs_t;

  suo_state_regs_t  r_r;
  suo_state_regs_t  r_nxt;
  suo_lop_t         lop;
  logic [63:0]      src_val;
  logic [63:0]      lres;
  logic [15:0]      quad;
  logic [63:0]      dbl;
  logic [31:0]      abs_val;
  logic             accept;
  logic [IDX_W-1:0] rd_idx;
  logic [IDX_W-1:0] wr_idx;

  suo_mem_if #(.IDX_W(IDX_W)) mem_if ();

  // ****************************************
  // register file and mask combiner
  // ****************************************
  suo_regfile #(
    .IDX_W (IDX_W)
  ) u_regfile (
    .clk_sys_in (clk_sys_in),
    .nrst_in    (nrst_in),
    .mem_if     (mem_if.mem)
  );

  suo_mask_logic u_mask_logic (
    .lop_in     (lop),
    .src_in     (src_val),
    .mask_in    (r_r.mask),
    .result_out (lres)
  );

  // ****************************************
  // issue: read and write indices
  // ****************************************
  assign op_ready_out = (r_r.st == SUO_ST_IDLE);
  assign accept       = op_valid_in && op_ready_out;

  always_comb begin
    rd_idx = op_src_idx_in;
    wr_idx = op_dst_idx_in;
    case (op_code_in)
      `SUO_OP_RELS_NARROW, `SUO_OP_RELS_WIDE: begin
        rd_idx = op_src_idx_in + r_r.rel[IDX_W-1:0];
      end
      `SUO_OP_RELD_NARROW, `SUO_OP_RELD_WIDE: begin
        wr_idx = op_dst_idx_in + r_r.rel[IDX_W-1:0];
      end
      `SUO_OP_DUAL_REL: begin
        rd_idx = op_src_idx_in + IDX_W'(r_r.rel[`SUO_DUAL_SRC_MSB:`SUO_DUAL_SRC_LSB]);
        wr_idx = op_dst_idx_in + IDX_W'(r_r.rel[`SUO_DUAL_DST_MSB:`SUO_DUAL_DST_LSB]);
      end
      default: begin
      end
    endcase
  end

  // ****************************************
  // operand shaping
  // ****************************************
  assign src_val = {mem_if.rd_hi, mem_if.rd_lo};

  for (genvar i = 0; i < 16; i++) begin : g_quad
    assign quad[i] = (src_val[i*4 +: 4] != 4'h0);
  end

  for (genvar i = 0; i < 32; i++) begin : g_dbl
    assign dbl[i*2 +: 2] = {2{src_val[i]}};
  end

  // two's complement wraps 0x80000000 onto itself
  assign abs_val = src_val[31] ? (32'h00000000 - src_val[31:0]) : src_val[31:0];

  always_comb begin
    unique case (r_r.op)
      `SUO_OP_AND_SAVE_NARROW:   lop = SUO_LOP_AND;
      `SUO_OP_OR_SAVE_NARROW:    lop = SUO_LOP_OR;
      `SUO_OP_XOR_SAVE_NARROW:   lop = SUO_LOP_XOR;
      `SUO_OP_ANDN2_SAVE_NARROW,
      `SUO_OP_ANDN2_WB_WIDE,
      `SUO_OP_ANDN2_WB_NARROW:   lop = SUO_LOP_ANDN2;
      `SUO_OP_ORN2_SAVE_NARROW:  lop = SUO_LOP_ORN2;
      `SUO_OP_NAND_SAVE_NARROW:  lop = SUO_LOP_NAND;
      `SUO_OP_NOR_SAVE_NARROW:   lop = SUO_LOP_NOR;
      `SUO_OP_XNOR_SAVE_NARROW,
      `SUO_OP_XNOR_SAVE_WIDE:    lop = SUO_LOP_XNOR;
      `SUO_OP_ANDN1_SAVE_NARROW,
      `SUO_OP_ANDN1_SAVE_WIDE,
      `SUO_OP_ANDN1_WB_WIDE,
      `SUO_OP_ANDN1_WB_NARROW:   lop = SUO_LOP_ANDN1;
      `SUO_OP_ORN1_SAVE_NARROW,
      `SUO_OP_ORN1_SAVE_WIDE:    lop = SUO_LOP_ORN1;
      default:                   lop = SUO_LOP_AND;
    endcase
  end

  // ****************************************
  // execute and state update
  // ****************************************
  always_comb begin
    r_nxt            = r_r;
    r_nxt.done       = 1'b0;
    mem_if.rd_idx    = accept ? rd_idx : host_rd_idx_in;
    mem_if.we_lo     = 1'b0;
    mem_if.we_hi     = 1'b0;
    mem_if.wr_idx    = r_r.widx;
    mem_if.wr_lo     = 32'h00000000;
    mem_if.wr_hi     = 32'h00000000;
    unique case (r_r.st)
      SUO_ST_IDLE: begin
        if (mask_ld_in) begin
          r_nxt.mask = mask_ld_data_in;
        end
        if (rel_ld_in) begin
          r_nxt.rel = rel_ld_data_in;
        end
        if (host_wr_en_in) begin
          mem_if.we_lo  = 1'b1;
          mem_if.wr_idx = host_wr_idx_in;
          mem_if.wr_lo  = host_wr_data_in;
        end
        if (accept) begin
          r_nxt.st   = SUO_ST_EXEC;
          r_nxt.op   = op_code_in;
          r_nxt.widx = wr_idx;
        end
      end
      SUO_ST_EXEC: begin
        r_nxt.st   = SUO_ST_IDLE;
        r_nxt.done = 1'b1;
        unique case (r_r.op)
          `SUO_OP_XNOR_SAVE_WIDE,
          `SUO_OP_ANDN1_SAVE_WIDE,
          `SUO_OP_ORN1_SAVE_WIDE: begin
            mem_if.we_lo = 1'b1;
            mem_if.we_hi = 1'b1;
            {mem_if.wr_hi, mem_if.wr_lo} = r_r.mask;
            r_nxt.mask   = lres;
            r_nxt.flag   = (lres != 64'h0000000000000000);
          end
          `SUO_OP_ANDN1_WB_WIDE,
          `SUO_OP_ANDN2_WB_WIDE: begin
            mem_if.we_lo = 1'b1;
            mem_if.we_hi = 1'b1;
            {mem_if.wr_hi, mem_if.wr_lo} = lres;
            r_nxt.mask   = lres;
            r_nxt.flag   = (lres != 64'h0000000000000000);
          end
          `SUO_OP_AND_SAVE_NARROW,
          `SUO_OP_OR_SAVE_NARROW,
          `SUO_OP_XOR_SAVE_NARROW,
          `SUO_OP_ANDN2_SAVE_NARROW,
          `SUO_OP_ORN2_SAVE_NARROW,
          `SUO_OP_NAND_SAVE_NARROW,
          `SUO_OP_NOR_SAVE_NARROW,
          `SUO_OP_XNOR_SAVE_NARROW,
          `SUO_OP_ANDN1_SAVE_NARROW,
          `SUO_OP_ORN1_SAVE_NARROW: begin
            mem_if.we_lo = 1'b1;
            mem_if.wr_lo = r_r.mask[31:0];
            r_nxt.mask   = {r_r.mask[63:32], lres[31:0]};
            r_nxt.flag   = (lres[31:0] != 32'h00000000);
          end
          `SUO_OP_ANDN1_WB_NARROW,
          `SUO_OP_ANDN2_WB_NARROW: begin
            mem_if.we_lo = 1'b1;
            mem_if.wr_lo = lres[31:0];
            r_nxt.mask   = {r_r.mask[63:32], lres[31:0]};
            r_nxt.flag   = (lres[31:0] != 32'h00000000);
          end
          `SUO_OP_QUAD_NARROW: begin
            mem_if.we_lo = 1'b1;
            mem_if.wr_lo = {24'h000000, quad[7:0]};
            r_nxt.flag   = (quad[7:0] != 8'h00);
          end
          `SUO_OP_QUAD_WIDE: begin
            mem_if.we_lo = 1'b1;
            mem_if.we_hi = 1'b1;
            mem_if.wr_lo = {16'h0000, quad};
            r_nxt.flag   = (quad != 16'h0000);
          end
          `SUO_OP_BIT_DOUBLE: begin
            mem_if.we_lo = 1'b1;
            mem_if.we_hi = 1'b1;
            {mem_if.wr_hi, mem_if.wr_lo} = dbl;
          end
          `SUO_OP_ABS: begin
            mem_if.we_lo = 1'b1;
            mem_if.wr_lo = abs_val;
            r_nxt.flag   = (abs_val != 32'h00000000);
          end
          `SUO_OP_RELS_NARROW,
          `SUO_OP_RELD_NARROW,
          `SUO_OP_DUAL_REL: begin
            mem_if.we_lo = 1'b1;
            mem_if.wr_lo = mem_if.rd_lo;
          end
          `SUO_OP_RELS_WIDE,
          `SUO_OP_RELD_WIDE: begin
            // pairs assume an even relative index from the sequencer
            mem_if.we_lo = 1'b1;
            mem_if.we_hi = 1'b1;
            {mem_if.wr_hi, mem_if.wr_lo} = src_val;
          end
          default: begin
            r_nxt.mask = r_r.mask;
          end
        endcase
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or negedge nrst_in) begin
    if (!nrst_in) begin
      r_r.st   <= SUO_ST_IDLE;
      r_r.op   <= '0;
      r_r.widx <= '0;
      r_r.mask <= `SUO_MASK_RST;
      r_r.flag <= `SUO_FLAG_RST;
      r_r.rel  <= `SUO_REL_RST;
      r_r.done <= 1'b0;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign op_done_out                 = r_r.done;
  assign host_rd_data_out            = mem_if.rd_lo;
  assign lane_enable_mask_out        = r_r.mask;
  assign cond_flag_out               = r_r.flag;
  assign relative_index_register_out = r_r.rel;

endmodule : suo_scalar_unary_mask_ops

/* suo_seq_model.sv */
// sequencer model: issues one decoded op at a time on the valid/ready port
// assumes the datapath raises done two cycles after it takes an op
`timescale 1ns/1ps

module suo_seq_model
  import suo_pkg::*;
(
  input  wire logic       clk_sys_in,
  input  wire logic       op_ready_in,
  input  wire logic       op_done_in,
  output logic            op_valid_out,
  output suo_opcode_t     op_code_out,
  output logic      [6:0] op_src_idx_out,
  output logic      [6:0] op_dst_idx_out
);
  initial begin
    op_valid_out = 1'b0;
    op_code_out = 7'h00;
    op_src_idx_out = 7'h00;
    op_dst_idx_out = 7'h00;
  end

  // fields are inverted on release so a stale op never looks valid
  task automatic send(input suo_opcode_t code, input logic [6:0] src, input logic [6:0] dst, output bit ok);
    ok = 1'b0;
    @(posedge clk_sys_in);
    op_valid_out <= 1'b1;
    op_code_out <= code;
    op_src_idx_out <= src;
    op_dst_idx_out <= dst;
    for (int i = 0; i < 16 && !ok; i++) begin
      #1;
      ok = op_ready_in;
      @(posedge clk_sys_in);
    end
    op_valid_out <= 1'b0;
    op_code_out <= ~code;
    op_src_idx_out <= ~src;
    op_dst_idx_out <= ~dst;
  endtask : send

  task automatic wait_done(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      @(posedge clk_sys_in);
      #1;
      ok = op_done_in;
    end
  endtask : wait_done

endmodule : suo_seq_model

/* tb.sv */
// testbench of the scalar mask/move datapath: host port, loads and op scenarios
// assumes suo_seq_model drives the op port and suo_asserts is bound to the datapath
`timescale 1ns/1ps

module tb
  import suo_pkg::*;
;
  logic        clk_sys_in = 1'b0;
  logic        nrst_in = 1'b0;
  logic        op_valid, op_ready, op_done, cond_flag;
  suo_opcode_t op_code;
  logic [6:0]  op_src, op_dst, host_rd_idx = 7'h00, host_wr_idx = 7'h00;
  logic        host_wr_en = 1'b0, mask_ld = 1'b0, rel_ld = 1'b0;
  logic [31:0] host_wr_data = 32'h0, rel_ld_data = 32'h0, host_rd_data, rel_val;
  logic [63:0] mask_ld_data = 64'h0, mask_val;
  int          n_mismatch = 0;
  int          num_checks = 0;

  suo_scalar_unary_mask_ops dut (
    .clk_sys_in(clk_sys_in), .nrst_in(nrst_in), .op_valid_in(op_valid), .op_ready_out(op_ready),
    .op_code_in(op_code), .op_src_idx_in(op_src), .op_dst_idx_in(op_dst), .op_done_out(op_done),
    .host_wr_en_in(host_wr_en), .host_wr_idx_in(host_wr_idx), .host_wr_data_in(host_wr_data),
    .host_rd_idx_in(host_rd_idx), .host_rd_data_out(host_rd_data), .mask_ld_in(mask_ld),
    .mask_ld_data_in(mask_ld_data), .rel_ld_in(rel_ld), .rel_ld_data_in(rel_ld_data),
    .lane_enable_mask_out(mask_val), .cond_flag_out(cond_flag), .relative_index_register_out(rel_val)
  );
  suo_seq_model u_seq (
    .clk_sys_in(clk_sys_in), .op_ready_in(op_ready), .op_done_in(op_done), .op_valid_out(op_valid),
    .op_code_out(op_code), .op_src_idx_out(op_src), .op_dst_idx_out(op_dst)
  );

  always #2.5 clk_sys_in = ~clk_sys_in;

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic wrap_up();
    if (n_mismatch == 0 && num_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    @(posedge clk_sys_in);
    host_wr_en <= 1'b1;
    host_wr_idx <= idx;
    host_wr_data <= d;
    @(posedge clk_sys_in);
    host_wr_en <= 1'b0;
  endtask : wr

  task automatic wr64(input logic [6:0] idx, input logic [63:0] d);
    wr(idx, d[31:0]);
    wr(idx + 7'h01, d[63:32]);
  endtask : wr64

  task automatic chk_reg(input logic [6:0] idx, input logic [31:0] exp);
    @(posedge clk_sys_in);
    host_rd_idx <= idx;
    @(posedge clk_sys_in);
    #1;
    chk("scalar_register", {32'h0, host_rd_data}, {32'h0, exp});
  endtask : chk_reg

  task automatic ld(input bit is_rel, input logic [63:0] v);
    @(posedge clk_sys_in);
    if (is_rel) rel_ld <= 1'b1;
    else mask_ld <= 1'b1;
    mask_ld_data <= v;
    rel_ld_data <= v[31:0];
    @(posedge clk_sys_in);
    mask_ld <= 1'b0;
    rel_ld <= 1'b0;
  endtask : ld

  task automatic run(input suo_opcode_t c, input logic [6:0] s, input logic [6:0] d);
    bit ok;
    u_seq.send(c, s, d, ok);
    if (ok) u_seq.wait_done(ok);
    if (!ok) begin
      n_mismatch++;
      wrap_up();
    end
  endtask : run

  function automatic logic [63:0] lop(input suo_opcode_t c, input logic [63:0] s, input logic [63:0] m);
    case (c)
      7'h2B, 7'h43: lop = ~(s ^ m);
      7'h37, 7'h39, 7'h44, 7'h46: lop = ~s & m;
      7'h38, 7'h45: lop = ~s | m;
      7'h3A, 7'h3F, 7'h47: lop = s & ~m;
      7'h3C: lop = s & m;
      7'h3D: lop = s | m;
      7'h3E: lop = s ^ m;
      7'h40: lop = s | ~m;
      7'h41: lop = ~(s & m);
      default: lop = ~(s | m);
    endcase
  endfunction : lop

  // ****************
  // scenarios
  // ****************
  task automatic s_mask_ops();
    logic [63:0] s, m, e;
    suo_opcode_t c, wl [5];
    bit wide, wb;
    wl = '{7'h2B, 7'h37, 7'h38, 7'h39, 7'h3A};
    for (int p = 0; p < 2; p++) begin
      s = p ? 64'hC3A5_5A3C_F00F_0FF0 : 64'h0F0F_3C3C_00FF_A5A5;
      m = p ? s : 64'h3355_F0F0_5A5A_0F0F;
      for (int k = 0; k < 17; k++) begin
        c = (k < 5) ? wl[k] : suo_opcode_t'(k + 55);
        wide = k < 5;
        wb = c inside {7'h39, 7'h3A, 7'h46, 7'h47};
        ld(1'b0, m);
        wr64(7'h0A, s);
        wr64(7'h14, 64'h1111_2222_3333_4444);
        run(c, 7'h0A, 7'h14);
        e = lop(c, s, m);
        if (!wide) e[63:32] = m[63:32];
        chk("lane_enable_mask", mask_val, e);
        chk("cond_flag", {63'h0, cond_flag}, {63'h0, wide ? |e : |e[31:0]});
        chk_reg(7'h14, wb ? e[31:0] : m[31:0]);
        chk_reg(7'h15, wide ? (wb ? e[63:32] : m[63:32]) : 32'h1111_2222);
      end
    end
  endtask : s_mask_ops

  task automatic s_quad();
    logic [63:0] s;
    logic [15:0] q;
    s = 64'hF000_0100_0000_20A0;
    for (int i = 0; i < 16; i++) q[i] = s[4*i +: 4] != 4'h0;
    wr64(7'h0A, s);
    wr64(7'h24, 64'h1111_2222_3333_4444);
    run(7'h2D, 7'h0A, 7'h20);
    chk("cond_flag", {63'h0, cond_flag}, 64'h1);
    chk_reg(7'h20, {16'h0, q});
    chk_reg(7'h21, 32'h0);
    run(7'h2C, 7'h0A, 7'h24);
    chk_reg(7'h24, {24'h0, q[7:0]});
    chk_reg(7'h25, 32'h1111_2222);
    wr(7'h0A, 32'h0);
    run(7'h2C, 7'h0A, 7'h24);
    chk("cond_flag", {63'h0, cond_flag}, 64'h0);
  endtask : s_quad

  task automatic s_b2b();
    logic [31:0] v;
    logic [63:0] d;
    logic [15:0] q;
    bit ok;
    v = 32'h8000_0005;
    for (int i = 0; i < 32; i++) d[2*i +: 2] = {2{v[i]}};
    for (int i = 0; i < 16; i++) q[i] = d[4*i +: 4] != 4'h0;
    wr(7'h0A, v);
    u_seq.send(7'h3B, 7'h0A, 7'h30, ok);
    if (ok) u_seq.send(7'h2D, 7'h30, 7'h40, ok);
    if (ok) u_seq.wait_done(ok);
    chk("op_done", {63'h0, ok}, 64'h1);
    if (!ok) wrap_up();
    chk_reg(7'h30, d[31:0]);
    chk_reg(7'h31, d[63:32]);
    chk_reg(7'h40, {16'h0, q});
  endtask : s_b2b

  task automatic s_abs();
    logic [31:0] v [6], e;
    v = '{32'h1, 32'h7FFF_FFFF, 32'h8000_0000, 32'h8000_0001, 32'hFFFF_FFFF, 32'h0};
    for (int i = 0; i < 6; i++) begin
      wr(7'h0A, v[i]);
      run(7'h34, 7'h0A, 7'h50);
      e = v[i][31] ? 32'h0 - v[i] : v[i];
      chk("cond_flag", {63'h0, cond_flag}, {63'h0, e != 32'h0});
      chk_reg(7'h50, e);
    end
  endtask : s_abs

  task automatic s_rel();
    wr64(7'h11, 64'hB2B2_0012_A1A1_0011);
    wr64(7'h07, 64'hD4D4_0008_C3C3_0007);
    ld(1'b1, 64'h0A);
    run(7'h2E, 7'h07, 7'h05);
    chk_reg(7'h05, 32'hA1A1_0011);
    run(7'h30, 7'h07, 7'h05);
    chk_reg(7'h0F, 32'hC3C3_0007);
    run(7'h2F, 7'h07, 7'h60);
    chk_reg(7'h61, 32'hB2B2_0012);
    run(7'h31, 7'h07, 7'h62);
    chk_reg(7'h6C, 32'hC3C3_0007);
    chk_reg(7'h6D, 32'hD4D4_0008);
    ld(1'b1, 64'h0014_000A);
    run(7'h49, 7'h07, 7'h05);
    chk("relative_index", {32'h0, rel_val}, 64'h0014_000A);
    chk_reg(7'h19, 32'hA1A1_0011);
  endtask : s_rel

  task automatic s_undef();
    suo_opcode_t u [5];
    u = '{7'h32, 7'h33, 7'h35, 7'h36, 7'h48};
    wr(7'h70, 32'h1234_5678);
    ld(1'b0, 64'h0123_4567_89AB_CDEF);
    for (int i = 0; i < 5; i++) begin
      run(u[i], 7'h0A, 7'h70);
      chk("lane_enable_mask", mask_val, 64'h0123_4567_89AB_CDEF);
      chk_reg(7'h70, 32'h1234_5678);
    end
  endtask : s_undef

  initial begin
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    #1;
    chk("lane_enable_mask", mask_val, 64'h0);
    chk("relative_index", {32'h0, rel_val}, 64'h0);
    chk("cond_flag", {63'h0, cond_flag}, 64'h0);
    chk("op_ready", {63'h0, op_ready}, 64'h1);
    chk("op_done", {63'h0, op_done}, 64'h0);
    s_mask_ops();
    s_quad();
    s_b2b();
    s_abs();
    s_rel();
    s_undef();
    wrap_up();
  end

endmodule : tb
